// >>> core/rmok_pkg.sv
// rmok_pkg: constants for the option and key register tail
// assumes a 20 MHz module clock
package rmok_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam logic [7:0] ADDR_OPTION = 8'h05;
    localparam logic [7:0] ADDR_KEY_HI = 8'h06;
    localparam logic [7:0] ADDR_KEY_LO = 8'h07;
    localparam int LBS_EN_BIT = 4;
    localparam int WOR_LSB = 0;
    localparam logic [7:0] OPTION_RST = 8'h00;
    localparam logic [7:0] KEY_RST = 8'h00;
    localparam int unsigned LBS_MAX_MS = 2000;
    localparam int unsigned WOR_STEP_MS = 500;
    localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;
    localparam int unsigned LBS_MAX_CYC = LBS_MAX_MS * CYC_PER_MS;
    localparam int unsigned WOR_STEP_CYC = WOR_STEP_MS * CYC_PER_MS;
    localparam logic [15:0] DEF_ADDR = 16'h0000;
    localparam logic [7:0] DEF_CHAN = 8'h23;
    localparam logic [7:0] DEF_SPEED = 8'h62;
    localparam logic [7:0] DEF_OPT1 = 8'h00;
    localparam logic [1:0] MODE_WOR_SEND = 2'h1;
endpackage

// >>> core/rmok_regs.sv
// rmok_regs: option/key registers, send deferral and wake timer
// assumes a host write/read port and synchronous radio status inputs
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - listen enabled: defer sending while channel busy
// - force transmit after two seconds of deferral
// - wake period is (field+1) times 500 ms
// - wake period used only in mode 1
// - key bytes writable, read back as zero
// - key bytes form sixteen-bit scramble factor
// - factory restore loads documented default set
module rmok_regs
    import rmok_pkg::*;
#(
    parameter int unsigned LBS_CYC = LBS_MAX_CYC,
    parameter int unsigned WOR_CYC = WOR_STEP_CYC
)
(
    input wire logic REF_CLK, // module clock
    input wire logic NRST, // async reset, active low
    input wire logic REG_WR, // register write strobe
    input wire logic REG_RD, // register read strobe
    input wire logic [7:0] REG_ADDR, // register address
    input wire logic [7:0] REG_WDATA, // write data
    output logic [7:0] REG_RDATA, // read data
    input wire logic FACTORY_RESTORE, // restore default pulse
    input wire logic MODE_SELECT_LOW, // mode pin low
    input wire logic MODE_SELECT_HIGH, // mode pin high
    input wire logic TX_REQ, // pending payload wants to send
    input wire logic CHAN_BUSY, // interference sensed
    output logic TX_GO, // transmit now pulse
    output logic WOR_TICK, // wake period elapsed pulse
    input wire logic [7:0] DATA_IN, // payload byte to scramble
    output logic [7:0] DATA_OUT, // scrambled payload byte
    output logic [15:0] KEY_FACTOR, // scramble factor
    output logic [15:0] DEF_ADDR_O, // default address
    output logic [7:0] DEF_CHAN_O, // default channel
    output logic [7:0] DEF_SPEED_O // default rate/baud/parity
);
    logic [7:0] option_q;
    logic [7:0] key_hi_q;
    logic [7:0] key_lo_q;
    logic [15:0] def_addr_q;
    logic [7:0] def_chan_q;
    logic [7:0] def_speed_q;
    logic [31:0] wait_q;
    logic [31:0] wor_q;
    logic [2:0] wor_idx_q;
    logic tx_go_q;
    logic wor_tick_q;
    logic [7:0] rdata_q;
    logic [7:0] dout_q;
    logic lbs_en;
    logic [1:0] mode;
    logic [31:0] wor_limit;

    assign lbs_en = option_q[LBS_EN_BIT];
    assign mode = {MODE_SELECT_HIGH, MODE_SELECT_LOW};
    // period counts in 500 ms steps
    assign wor_limit = WOR_CYC - 32'd1;

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            option_q <= OPTION_RST;
            key_hi_q <= KEY_RST;
            key_lo_q <= KEY_RST;
        end
        else if (FACTORY_RESTORE)
        begin
            option_q <= DEF_OPT1;
            key_hi_q <= KEY_RST;
            key_lo_q <= KEY_RST;
        end
        else if (REG_WR)
        begin
            if (REG_ADDR == ADDR_OPTION)
                option_q <= REG_WDATA;
            if (REG_ADDR == ADDR_KEY_HI)
                key_hi_q <= REG_WDATA;
            if (REG_ADDR == ADDR_KEY_LO)
                key_lo_q <= REG_WDATA;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            def_addr_q <= 16'h0000;
            def_chan_q <= 8'h00;
            def_speed_q <= 8'h00;
        end
        else if (FACTORY_RESTORE)
        begin
            def_addr_q <= DEF_ADDR;
            def_chan_q <= DEF_CHAN;
            def_speed_q <= DEF_SPEED;
        end
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
            rdata_q <= 8'h00;
        else if (REG_RD)
            // key locations always read zero
            rdata_q <= (REG_ADDR == ADDR_OPTION) ? option_q : 8'h00;
    end

    // deferral timer: counts while busy with a pending send
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wait_q <= 32'h0;
            tx_go_q <= 1'b0;
        end
        else if (tx_go_q || !TX_REQ)
        begin
            wait_q <= 32'h0;
            tx_go_q <= 1'b0;
        end
        else if (lbs_en && CHAN_BUSY && wait_q < LBS_CYC - 32'd1)
            wait_q <= wait_q + 32'd1;
        else
            tx_go_q <= 1'b1;
    end

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            wor_q <= 32'h0;
            wor_idx_q <= 3'h0;
            wor_tick_q <= 1'b0;
        end
        else if (mode != MODE_WOR_SEND)
        begin
            wor_q <= 32'h0;
            wor_idx_q <= 3'h0;
            wor_tick_q <= 1'b0;
        end
        else if (wor_q < wor_limit)
        begin
            wor_q <= wor_q + 32'd1;
            wor_tick_q <= 1'b0;
        end
        else
        begin
            wor_q <= 32'h0;
            if (wor_idx_q >= option_q[WOR_LSB +: 3])
            begin
                wor_idx_q <= 3'h0;
                wor_tick_q <= 1'b1;
            end
            else
            begin
                wor_idx_q <= wor_idx_q + 3'h1;
                wor_tick_q <= 1'b0;
            end
        end
    end

    assign KEY_FACTOR = {key_hi_q, key_lo_q};

    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
            dout_q <= 8'h00;
        else
            dout_q <= DATA_IN ^ key_hi_q ^ key_lo_q;
    end

    assign REG_RDATA = rdata_q;
    assign TX_GO = tx_go_q;
    assign WOR_TICK = wor_tick_q;
    assign DATA_OUT = dout_q;
    assign DEF_ADDR_O = def_addr_q;
    assign DEF_CHAN_O = def_chan_q;
    assign DEF_SPEED_O = def_speed_q;

    key_read_zero_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        REG_RD && (REG_ADDR == ADDR_KEY_HI || REG_ADDR == ADDR_KEY_LO)
        |=> REG_RDATA == 8'h00)
        else $error("key read not zero");
    key_write_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        REG_WR && !FACTORY_RESTORE && REG_ADDR == ADDR_KEY_HI
        |=> KEY_FACTOR[15:8] == $past(REG_WDATA))
        else $error("key high not stored");
    key_low_write_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        REG_WR && !FACTORY_RESTORE && REG_ADDR == ADDR_KEY_LO
        |=> KEY_FACTOR[7:0] == $past(REG_WDATA))
        else $error("key low not stored");
    scramble_out_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        1'b1 |=> DATA_OUT ==
            ($past(DATA_IN) ^ $past(key_hi_q) ^ $past(key_lo_q)))
        else $error("payload not scrambled");
    tx_defer_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        TX_REQ && lbs_en && CHAN_BUSY && !tx_go_q && wait_q == 32'h0
        |=> !TX_GO)
        else $error("sent while busy");
    tx_force_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        wait_q >= LBS_CYC - 32'd1 && TX_REQ && !tx_go_q |=> TX_GO)
        else $error("no forced send");
    wor_mode_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        mode != MODE_WOR_SEND |=> !WOR_TICK)
        else $error("wake tick outside mode 1");
    wor_gap_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        WOR_TICK |=> !WOR_TICK)
        else $error("wake tick repeated");
    restore_a: assert property (@(posedge REF_CLK)
        disable iff (!NRST)
        FACTORY_RESTORE |=> DEF_CHAN_O == DEF_CHAN && KEY_FACTOR == 16'h0000)
        else $error("restore defaults wrong");
    reset_key_a: assert property (@(posedge REF_CLK)
        $rose(NRST) |-> KEY_FACTOR == 16'h0000)
        else $error("key not zero after reset");
endmodule
`default_nettype wire

// >>> testbench/radio_module_option_key_regs_tb.sv
// radio_module_option_key_regs_tb: directed checks of the register tail
// assumes rmok_host drives the register port
`timescale 1ns/10ps
`default_nettype none
module radio_module_option_key_regs_tb
    import rmok_pkg::*;
;
    localparam int LBS_T = 20; // short deferral limit for simulation
    localparam int WOR_T = 5; // short wake step for simulation
    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic mlo = 1'b0, mhi = 1'b0, req = 1'b0, busy = 1'b0, rst = 1'b0;
    logic wr, rd, go, tick;
    logic [7:0] addr, wdata, rdata, dchan, dspd, v;
    logic [7:0] din = 8'h00, dout;
    logic [15:0] kf, daddr;
    int bad_count = 0, checked = 0, n;
    always #25 REF_CLK = ~REF_CLK;
    rmok_regs #(.LBS_CYC(LBS_T), .WOR_CYC(WOR_T)) dut_u (.REF_CLK(REF_CLK),
        .NRST(NRST), .REG_WR(wr), .REG_RD(rd), .REG_ADDR(addr),
        .REG_WDATA(wdata), .REG_RDATA(rdata), .FACTORY_RESTORE(rst),
        .MODE_SELECT_LOW(mlo), .MODE_SELECT_HIGH(mhi), .TX_REQ(req),
        .CHAN_BUSY(busy), .TX_GO(go), .WOR_TICK(tick), .DATA_IN(din),
        .DATA_OUT(dout), .KEY_FACTOR(kf), .DEF_ADDR_O(daddr),
        .DEF_CHAN_O(dchan), .DEF_SPEED_O(dspd));
    rmok_host host_u (.clk(REF_CLK), .wr(wr), .rd(rd), .addr(addr),
        .wdata(wdata), .rdata(rdata));
    task automatic give_verdict();
        if (bad_count == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e)
        begin
            bad_count++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    // cycles until the next wake tick (t=1) or transmit pulse (t=0)
    task automatic cnt(input bit t, output int c);
        c = 0;
        do
        begin
            @(posedge REF_CLK);
            #1;
            c++;
        end while ((t ? tick : go) !== 1'b1 && c < 99);
    endtask
    task automatic send(input logic b, output int c);
        @(posedge REF_CLK);
        busy <= b;
        req <= 1'b1;
        cnt(0, c);
        @(posedge REF_CLK);
        req <= 1'b0;
    endtask
    // first tick lines up, second spans one full wake period
    task automatic wor_case(input logic [2:0] f);
        host_u.put(ADDR_OPTION, {5'h00, f});
        cnt(1, n);
        cnt(1, n);
        cmp(16'(({13'h0, f} + 16'd1) * WOR_T), 16'(n));
    endtask
    // no wake tick may appear within the wait limit
    task automatic idle_case(input logic hi, input logic lo);
        @(posedge REF_CLK);
        mhi <= hi;
        mlo <= lo;
        cnt(1, n);
        cmp(16'd99, 16'(n));
    endtask
    initial
    begin
        repeat (6) @(posedge REF_CLK);
        NRST <= 1'b1;
        cmp(16'h0000, kf);
        host_u.put(ADDR_KEY_HI, 8'hAB);
        host_u.put(ADDR_KEY_LO, 8'hCD);
        cmp(16'hABCD, kf);
        host_u.get(ADDR_KEY_HI, v);
        cmp(16'h0000, {8'h00, v});
        host_u.get(ADDR_KEY_LO, v);
        cmp(16'h0000, {8'h00, v});
        @(posedge REF_CLK);
        din <= 8'h5A;
        repeat (2) @(posedge REF_CLK);
        #1;
        cmp(16'h003C, {8'h00, dout});
        @(posedge REF_CLK);
        mlo <= 1'b1;
        wor_case(3'h7);
        wor_case(3'h2);
        wor_case(3'h0);
        idle_case(1'b0, 1'b0);
        idle_case(1'b1, 1'b0);
        idle_case(1'b1, 1'b1);
        host_u.put(ADDR_OPTION, 8'h00);
        send(1'b1, n);
        cmp(16'd1, 16'(n));
        host_u.put(ADDR_OPTION, 8'h10);
        host_u.get(ADDR_OPTION, v);
        cmp(16'h0010, {8'h00, v});
        send(1'b0, n);
        cmp(16'd1, 16'(n));
        send(1'b1, n);
        cmp(16'd1, {15'h0, n inside {[20:22]}});
        busy <= 1'b0;
        @(posedge REF_CLK);
        NRST <= 1'b0;
        @(posedge REF_CLK);
        NRST <= 1'b1;
        #1;
        cmp(16'h0000, kf);
        @(posedge REF_CLK);
        rst <= 1'b1;
        @(posedge REF_CLK);
        rst <= 1'b0;
        #1;
        cmp(16'h0000, daddr);
        cmp(16'h0023, {8'h00, dchan});
        cmp({8'h00, DEF_SPEED}, {8'h00, dspd});
        give_verdict();
    end
    initial
    begin
        repeat (3000) @(posedge REF_CLK);
        bad_count++;
        give_verdict();
    end
endmodule
`default_nettype wire

// >>> testbench/rmok_host.sv
// rmok_host: host controller model issuing register commands
// assumes strobes are sampled on the rising clock edge
`timescale 1ns/10ps
`default_nettype none
module rmok_host (
    input wire logic clk, // module clock
    output logic wr, // write strobe
    output logic rd, // read strobe
    output logic [7:0] addr, // register address
    output logic [7:0] wdata, // write data
    input wire logic [7:0] rdata // read data
);
    initial
    begin
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
    end
    // bus lines are inverted once released so stale values never match
    task automatic put(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
        #1;
    endtask
    task automatic get(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        addr <= ~a;
        @(posedge clk);
        #1;
        v = rdata;
    endtask
endmodule
`default_nettype wire
